// ### rtl/grt_timer.v
// Five reloading 16-bit down timers with gate input and shared prescaler.
// Assumes a classic Wishbone master and tick inputs synchronous to clk_i.
//
// Operation
// - Start set and gate active: counter decrements once per source tick.
// - Gate inactive: counter holds its value until gate returns.
// - Underflow copies reload value into counter, counting carries on.
// - Every underflow sets that timer's interrupt request bit.
// - Clearing the start flag halts the counter, value kept.
// - Gate option: disabled, count while low, or count while high.
// - Per-timer polarity picks high-active or inverted pulse output.
// - Extended enable 0: two-bit mode field picks base, /8, /32, sub/32.
// - Extended enable 1: three-bit code picks one of seven sources.
// - Predivide select 1: alternate clock, only codes 000 to 011 valid.
// - Select registers hold timer nibbles: 0/1, 2/3, then 4 low.
// - Halving bit 1 gives undivided base clock, 0 gives half rate.
// - Prescaler reset flag: 1 resets prescaler, 0 nothing, reads 0.
// - Each timer has a 16-bit counter/reload in low and high bytes.
`timescale 1ns/1ps
`default_nettype none
`include "grt_regs.vh"

module grt_timer #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Count source ticks
  input  wire        alt_clk_tick_i,
  input  wire        fast_osc_tick_i,
  input  wire        slow_osc_tick_i,
  input  wire        subclk_tick_i,
  // Timer pins
  input  wire [4:0]  gate_input_pin_i,
  output reg  [4:0]  pulse_output_pin_o,
  output reg  [4:0]  pulse_output_oe_o,
  // Interrupt
  output wire        irq_o
);

  localparam NT = 5;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  reg         ack_q;
  wire        req;
  wire        wr;
  wire [7:0]  off;
  wire        in_mode;
  wire        in_count;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i;
  assign off      = {wb_adr_i[7:2], 2'b00};
  assign in_mode  = (off[7:5] == `GRT_MODE_PAGE) && (off[4:2] < 3'h5);
  assign in_count = (off[7:5] == `GRT_COUNT_PAGE) && (off[4:2] < 3'h5);
  assign wb_ack_o = ack_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // ****************************************************************
  // Shared control registers
  // ****************************************************************
  reg  [4:0]      start_q;
  reg             predivision_clock_select_q;
  reg             peripheral_clock_halving_q;
  reg  [19:0]     src_sel_q;
  reg  [4:0]      pol_q;
  reg  [4:0]      irq_en_q;
  reg  [4:0]      irq_st_q;
  wire [4:0]      uf;
  wire            ps_reset;
  wire [4:0]      irq_clr;
  wire [NT*8-1:0] mode_flat;
  wire [NT*CNT_W-1:0] cnt_flat;

  // Prescaler reset is a pulse; the flag itself is never stored
  // prescaler reset strobe
  assign ps_reset = wr && (off == `GRT_ADR_CTRL) && wb_sel_i[2] &&
                    wb_dat_i[`GRT_CTRL_PSRESET];
  assign irq_clr  = (wr && (off == `GRT_ADR_IRQ_CLR) && wb_sel_i[0]) ?
                    wb_dat_i[4:0] : 5'h00;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_q                    <= 5'h00;
      predivision_clock_select_q <= 1'b0;
      peripheral_clock_halving_q <= 1'b0;
      src_sel_q                  <= 20'h00000;
      pol_q                      <= 5'h00;
      irq_en_q                   <= 5'h00;
    end
    else if (wr)
    begin
      if (off == `GRT_ADR_CTRL && wb_sel_i[0])
        start_q <= wb_dat_i[`GRT_CTRL_START_LSB+4:`GRT_CTRL_START_LSB];
      if (off == `GRT_ADR_CTRL && wb_sel_i[1])
      begin
        predivision_clock_select_q <= wb_dat_i[`GRT_CTRL_PREDIV];
        peripheral_clock_halving_q <= wb_dat_i[`GRT_CTRL_HALVING];
      end
      if (off == `GRT_ADR_SRCSEL0 && wb_sel_i[0])
        src_sel_q[7:0] <= wb_dat_i[7:0];
      if (off == `GRT_ADR_SRCSEL1 && wb_sel_i[0])
        src_sel_q[15:8] <= wb_dat_i[7:0];
      if (off == `GRT_ADR_SRCSEL2 && wb_sel_i[0])
        src_sel_q[19:16] <= wb_dat_i[3:0];
      if (off == `GRT_ADR_POL && wb_sel_i[0])
        pol_q <= wb_dat_i[4:0];
      if (off == `GRT_ADR_IRQ_EN && wb_sel_i[0])
        irq_en_q <= wb_dat_i[4:0];
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // sticky request, set beats clear
  always @(posedge clk_i)
  begin
    if (rst_i)
      irq_st_q <= 5'h00;
    else
      irq_st_q <= (irq_st_q & ~irq_clr) | uf;
  end

  assign irq_o = |(irq_st_q & irq_en_q);

  // ****************************************************************
  // Prescalers
  // ****************************************************************
  reg  [5:0] ps_q;
  reg  [4:0] sub_q;
  wire       base_en;
  wire       tick_div2;
  wire       tick_base;
  wire       tick_div8;
  wire       tick_div32;
  wire       tick_div64;
  wire       tick_sub32;

  assign base_en    = predivision_clock_select_q ? alt_clk_tick_i : 1'b1;
  assign tick_div2  = base_en & ps_q[0];
  // halving picks full or half rate
  assign tick_base  = peripheral_clock_halving_q ? base_en : tick_div2;
  assign tick_div8  = base_en & (&ps_q[2:0]);
  assign tick_div32 = base_en & (&ps_q[4:0]);
  assign tick_div64 = base_en & (&ps_q[5:0]);
  assign tick_sub32 = subclk_tick_i & (&sub_q);

  always @(posedge clk_i)
  begin
    if (rst_i || ps_reset)
    begin
      ps_q  <= 6'h00;
      sub_q <= 5'h00;
    end
    else
    begin
      if (base_en)
        ps_q <= ps_q + 6'h01;
      if (subclk_tick_i)
        sub_q <= sub_q + 5'h01;
    end
  end

  // ****************************************************************
  // Timer channels
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < NT; i = i + 1)
    begin : g_tmr
      reg  [7:0]       mode_q;
      reg  [CNT_W-1:0] reload_q;
      reg  [CNT_W-1:0] cnt_q;
      reg  [CNT_W-1:0] reload_d;
      reg              tog_q;
      reg              tick;
      wire [3:0]       nib;
      wire [1:0]       gate_sel;
      wire             gate_ok;
      wire             run;
      wire             sel_me;

      assign nib      = src_sel_q[4*i+3:4*i];
      assign gate_sel = mode_q[`GRT_MODE_GATE_MSB:`GRT_MODE_GATE_LSB];
      assign sel_me   = (off[4:2] == i);

      assign gate_ok  = (gate_sel == `GRT_GATE_LOW)  ? ~gate_input_pin_i[i] :
                        (gate_sel == `GRT_GATE_HIGH) ?  gate_input_pin_i[i] :
                        1'b1;

      // Source selection
      always @*
      begin
        tick = 1'b0;
        if (!nib[3])
        begin
          case (mode_q[`GRT_MODE_SRC_MSB:`GRT_MODE_SRC_LSB])
            2'h0:    tick = tick_base;
            2'h1:    tick = tick_div8;
            2'h2:    tick = tick_div32;
            default: tick = tick_sub32;
          endcase
        end
        else
        begin
          // extended code, limits it under alternate clock
          case (nib[2:0])
            `GRT_SRC_BASE:  tick = tick_base;
            `GRT_SRC_DIV8:  tick = tick_div8;
            `GRT_SRC_DIV32: tick = tick_div32;
            `GRT_SRC_DIV64: tick = tick_div64;
            `GRT_SRC_FAST:  tick = fast_osc_tick_i &
                                   ~predivision_clock_select_q;
            `GRT_SRC_SLOW:  tick = slow_osc_tick_i &
                                   ~predivision_clock_select_q;
            `GRT_SRC_SUB32: tick = tick_sub32 &
                                   ~predivision_clock_select_q;
            default:        tick = 1'b0;
          endcase
        end
      end

      assign run   = tick & start_q[i] & gate_ok;
      // underflow on a tick taken at zero
      assign uf[i] = run & (cnt_q == {CNT_W{1'b0}});

      // byte lanes of the reload value
      always @*
      begin
        reload_d = reload_q;
        if (wb_sel_i[0])
          reload_d[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1])
          reload_d[CNT_W-1:8] = wb_dat_i[CNT_W-1:8];
      end

      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          mode_q   <= `GRT_RST_BYTE;
          reload_q <= `GRT_RST_COUNT;
          cnt_q    <= `GRT_RST_COUNT;
          tog_q    <= 1'b0;
        end
        else
        begin
          if (wr && in_mode && sel_me && wb_sel_i[0])
            mode_q <= wb_dat_i[7:0];
          if (wr && in_count && sel_me)
          begin
            reload_q <= reload_d;
            // stopped write also loads the counter
            if (!start_q[i])
              cnt_q <= reload_d;
          end
          if (run)
          begin
            if (uf[i])
              cnt_q <= reload_q;
            else
              cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          end
          if (uf[i])
            tog_q <= ~tog_q;
        end
      end

      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pulse_output_pin_o[i] <= 1'b0;
          pulse_output_oe_o[i]  <= 1'b0;
        end
        else
        begin
          pulse_output_pin_o[i] <= tog_q ^ pol_q[i];
          pulse_output_oe_o[i]  <= mode_q[`GRT_MODE_PULSE_EN];
        end
      end

      assign mode_flat[8*i+7:8*i]           = mode_q;
      assign cnt_flat[CNT_W*i+CNT_W-1:CNT_W*i] = cnt_q;
    end
  endgenerate

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unmapped words and write-only words read as zero
  reg [31:0] rd_d;

  always @*
  begin
    rd_d = 32'h00000000;
    case (off)
      `GRT_ADR_CTRL:
      begin
        rd_d[`GRT_CTRL_START_LSB+4:`GRT_CTRL_START_LSB] = start_q;
        rd_d[`GRT_CTRL_PREDIV]  = predivision_clock_select_q;
        rd_d[`GRT_CTRL_HALVING] = peripheral_clock_halving_q;
      end
      `GRT_ADR_SRCSEL0: rd_d[7:0] = src_sel_q[7:0];
      `GRT_ADR_SRCSEL1: rd_d[7:0] = src_sel_q[15:8];
      `GRT_ADR_SRCSEL2: rd_d[3:0] = src_sel_q[19:16];
      `GRT_ADR_POL:     rd_d[4:0] = pol_q;
      `GRT_ADR_IRQ_ST:  rd_d[4:0] = irq_st_q;
      `GRT_ADR_IRQ_EN:  rd_d[4:0] = irq_en_q;
      default:
      begin
        if (in_mode)
          rd_d[7:0] = mode_flat[8*off[4:2] +: 8];
        else if (in_count)
          rd_d[CNT_W-1:0] = cnt_flat[CNT_W*off[4:2] +: CNT_W];
      end
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (req)
      wb_dat_o <= rd_d;
  end

endmodule

`default_nettype wire

// ### rtl/grt_regs.vh
// Register offsets, field positions and reset values of the gated timer.
// Assumes a byte-addressed 32-bit classic Wishbone slave, one word each.
`ifndef GRT_REGS_VH
`define GRT_REGS_VH

// ****************************************************************
// Word offsets
// ****************************************************************
`define GRT_ADR_CTRL     8'h00
`define GRT_ADR_SRCSEL0  8'h04
`define GRT_ADR_SRCSEL1  8'h08
`define GRT_ADR_SRCSEL2  8'h0C
`define GRT_ADR_POL      8'h10
`define GRT_ADR_IRQ_ST   8'h14
`define GRT_ADR_IRQ_CLR  8'h18
`define GRT_ADR_IRQ_EN   8'h1C
`define GRT_MODE_PAGE    3'h1
`define GRT_COUNT_PAGE   3'h2

// ****************************************************************
// Control word fields
// ****************************************************************
`define GRT_CTRL_START_LSB  0
`define GRT_CTRL_PREDIV     8
`define GRT_CTRL_HALVING    9
`define GRT_CTRL_PSRESET    16

// ****************************************************************
// Mode register fields
// ****************************************************************
`define GRT_MODE_PULSE_EN   2
`define GRT_MODE_GATE_MSB   4
`define GRT_MODE_GATE_LSB   3
`define GRT_MODE_SRC_MSB    7
`define GRT_MODE_SRC_LSB    6
`define GRT_GATE_LOW        2'h2
`define GRT_GATE_HIGH       2'h3

// ****************************************************************
// Extended source codes
// ****************************************************************
`define GRT_SRC_BASE   3'h0
`define GRT_SRC_DIV8   3'h1
`define GRT_SRC_DIV32  3'h2
`define GRT_SRC_DIV64  3'h3
`define GRT_SRC_FAST   3'h4
`define GRT_SRC_SLOW   3'h5
`define GRT_SRC_SUB32  3'h6

// ****************************************************************
// Reset values
// ****************************************************************
`define GRT_RST_BYTE   8'h00
`define GRT_RST_COUNT  16'h0000

`endif

// ### testbench/grt_timer_sva.sv
// Port checker for the gated reload timer.
// Assumes one clock and a classic Wishbone master.
`timescale 1ns/1ps
`default_nettype none
module grt_timer_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic [4:0]  pulse_output_oe_o,
  input wire logic        irq_o
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Read answer in the ack cycle
  wire rd_ack = wb_ack_o && !wb_we_i;
  AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  AST_ACK_ONE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_NO_REQ:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_PSR_ZERO:
    assert property (rd_ack && wb_adr_i == 8'h00 |-> !wb_dat_o[16])
    else $error("prescaler reset reads one");
  AST_SEL2_HI:
    assert property (rd_ack && wb_adr_i == 8'h0C |-> wb_dat_o[31:4] == 28'h0)
    else $error("select 2 upper bits set");
  AST_ST_WIDTH:
    assert property (rd_ack && wb_adr_i == 8'h14 |-> wb_dat_o[31:5] == 27'h0)
    else $error("status upper bits set");
  AST_CNT_WIDTH:
    assert property (rd_ack && wb_adr_i[7:6] == 2'h1
                     |-> wb_dat_o[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  AST_UNMAPPED:
    assert property (rd_ack && wb_adr_i == 8'hFC |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RST_QUIET:
    assert property ($fell(rst_i) |-> !irq_o && pulse_output_oe_o == 5'h0)
    else $error("outputs active after reset");
endmodule

bind grt_timer grt_timer_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pulse_output_oe_o(pulse_output_oe_o), .irq_o(irq_o));
`default_nettype wire

// ### testbench/grt_gate_src.sv
// External gate driver for the five gate pins.
// Assumes requests from the bench, synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module grt_gate_src #(
  parameter int MIN_HOLD = 8
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Level request and pins
  input  wire logic [4:0] lvl_req_i,
  output var  logic [4:0] gate_o
);
  int age_q;
  // minimum level hold
  // Late change beats a glitch the timer could miss
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate_o <= 5'h0;
      age_q  <= 0;
    end
    else if (lvl_req_i != gate_o && age_q >= MIN_HOLD)
    begin
      gate_o <= lvl_req_i;
      age_q  <= 0;
    end
    else
      age_q <= age_q + 1;
  end
endmodule
`default_nettype wire

// ### testbench/grt_timer_tb_top.sv
// Bench for the gated reload timer over Wishbone.
// Assumes grt_timer, grt_gate_src and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module grt_timer_tb_top;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq, p;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [7:0]  tc = 8'h0;
  logic [31:0] dat, rdat, q;
  logic [4:0]  req, gate, pin, oe;
  logic [39:0] tbl [16];
  int          err_total, compares, cyc_n;

  grt_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .alt_clk_tick_i(tc[1:0] == 2'h0), .fast_osc_tick_i(tc[0]),
    .slow_osc_tick_i(tc[2:0] == 3'h0), .subclk_tick_i(tc[0]),
    .gate_input_pin_i(gate), .pulse_output_pin_o(pin),
    .pulse_output_oe_o(oe), .irq_o(irq));
  grt_gate_src i_gate (.clk_i(clk_i), .rst_i(rst_i), .lvl_req_i(req),
    .gate_o(gate));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Tick pattern: alt /4, fast /2, slow /8, sub /2
  always @(posedge clk_i)
  begin
    tc <= tc + 8'h1;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 10000)
    begin
      err_total++;
      end_of_test;
    end
  end

  task end_of_test;
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  // Classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(s, e, q);
  endtask

  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, dat, sel, req} = '0;
    // Mode, select, control, window level, expected decrement
    tbl = '{40'h18_00_201_1_80, 40'h18_00_001_1_40, 40'h58_00_201_1_10,
            40'h98_00_201_1_04, 40'hD8_00_201_1_02, 40'h18_0B_201_1_02,
            40'h10_00_201_0_80, 40'h10_00_201_1_00, 40'h18_08_301_1_20,
            40'h18_0C_301_1_00, 40'h18_0C_201_1_40, 40'h18_0D_201_1_10,
            40'h18_09_201_1_10, 40'h18_0A_201_1_04, 40'h18_0E_201_1_02,
            40'h18_0F_201_1_00};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 32'h0, "ctrl");
    rd(8'h14, 32'h0, "status");
    rd(8'hFC, 32'h0, "unmapped");
    wr(8'h00, 32'h10200);
    rd(8'h00, 32'h200, "psr");
    wr(8'h0C, 32'hFF);
    rd(8'h0C, 32'hF, "sel2");
    // Halving first, then sources and gate, predivide cases, then the other extended codes
    foreach (tbl[i])
    begin
      req <= {4'h0, ~tbl[i][35]};
      wr(8'h00, {20'h0, tbl[i][23:13], 1'b0});
      wr(8'h20, {24'h0, tbl[i][39:32]});
      wr(8'h04, {24'h0, tbl[i][31:24]});
      wr(8'h40, 32'h1000);
      wr(8'h00, {20'h0, tbl[i][23:12]});
      req <= {4'h0, tbl[i][8]};
      repeat (128) @(posedge clk_i);
      req <= {4'h0, ~tbl[i][35]};
      // idle level held sixteen slow periods
      repeat (128) @(posedge clk_i);
      rd(8'h40, 32'h1000 - tbl[i][7:0], "count");
    end
    wr(8'h00, 32'h200);
    wr(8'h20, 32'h1C);
    wr(8'h04, 32'h0);
    wr(8'h40, 32'h3);
    req <= 5'h0;
    wr(8'h00, 32'h201);
    wr(8'h40, 32'h9);
    rd(8'h40, 32'h3, "run write");
    req <= 5'h1;
    repeat (30) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h200);
    rd(8'h14, 32'h1, "status");
    rd(8'h40, 32'h3, "reloaded");
    chk("oe", 32'h1, {31'h0, oe[0]});
    wr(8'h1C, 32'h1);
    chk("irq on", 32'h1, {31'h0, irq});
    p = pin[0];
    wr(8'h10, 32'h1);
    chk("pol", {31'h0, ~p}, {31'h0, pin[0]});
    wr(8'h18, 32'h1);
    chk("irq clr", 32'h0, {31'h0, irq});
    wb(1'b1, 8'h40, 32'h1234, 4'hF);
    wb(1'b1, 8'h40, 32'hAB, 4'h1);
    rd(8'h40, 32'h12AB, "low byte");
    end_of_test;
  end
endmodule
`default_nettype wire
